//--- verif/amsa_bus_partner.sv
// Bus model of the requesting masters and of the slave's ready line.
`timescale 1ns/1ps
`default_nettype none
module amsa_bus_partner
    import amsa_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Arbiter side
    input wire logic [5:0] req,
    input wire logic grant_valid,
    input wire logic [2:0] grant_idx,
    // Transfer shape per master
    input wire logic [5:0][2:0] hb,
    input wire logic [5:0][8:0] ln,
    input wire logic slow,
    // Bus seen by the arbiter
    output logic [1:0] htrans,
    output logic [2:0] hburst,
    output var logic hready
);
    logic [8:0] beat_q;
    logic [2:0] own_q;
    logic own_v_q;
    logic [8:0] eff;
    logic act;
    // Count restarts whenever ownership moves; an owner that keeps the grant idles one cycle between bursts
    assign eff = (own_v_q && own_q == grant_idx) ? beat_q : 9'h000;
    assign act = grant_valid && req[grant_idx] && (eff < ln[grant_idx]);
    assign htrans = !act ? AMSA_HT_IDLE : (eff == 9'h000) ? AMSA_HT_NONSEQ : 2'h3;
    assign hburst = hb[grant_idx];
    // Beat tracking of the current owner
    always_ff @(posedge mclk) begin
        own_q <= grant_idx;
        own_v_q <= grant_valid && !rst;
        if (rst || !act) begin
            beat_q <= 9'h000;
        end else begin
            beat_q <= eff + {8'h00, hready};
        end
    end
    // Slow slave stalls at random, even while idle
    always_ff @(posedge mclk) begin
        if (rst) begin
            hready <= 1'b1;
        end else begin
            hready <= slow ? 1'($urandom) : 1'b1;
        end
    end
endmodule // amsa_bus_partner
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench: grant order, burst cuts, slot limit, registers, write protect.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import amsa_pkg::*;
;
    logic mclk, rst, ce, reg_wr, reg_rd, grant_valid, bus_hready, bus_lock, slow;
    logic [5:0] req;
    logic [1:0] bus_htrans;
    logic [2:0] bus_hburst, grant_idx;
    logic [8:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [5:0][2:0] hb;
    logic [5:0][8:0] ln;
    logic [63:0] rq[$];
    logic [31:0] gq[$];
    logic [31:0] bq[$];
    logic chk_en = 1'b0;
    logic bt_en = 1'b0;
    logic rd_pend = 1'b0;
    logic pv = 1'b0;
    logic [2:0] pi = 3'h0;
    logic [31:0] bcnt = 32'h0;
    int mismatches = 0;
    int samples_checked = 0;

    // Clock at 250 MHz
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    amsa_slave_arbiter #(.NM(6), .LW(2)) u_dut (.mclk(mclk), .rst(rst), .ce(ce), .req(req),
        .bus_htrans(bus_htrans), .bus_hburst(bus_hburst), .bus_hready(bus_hready), .bus_lock(bus_lock),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .grant_valid(grant_valid), .grant_idx(grant_idx));
    amsa_bus_partner u_bus (.mclk(mclk), .rst(rst), .req(req), .grant_valid(grant_valid),
        .grant_idx(grant_idx), .hb(hb), .ln(ln), .slow(slow), .htrans(bus_htrans),
        .hburst(bus_hburst), .hready(bus_hready));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("mismatches %0d, samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic wr(input logic [8:0] a, input logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        // Idle edge, so a following call never drives the strobe twice in one step
        @(posedge mclk);
    endtask

    // Expected read word noted with a mask of the bits that matter
    task automatic rd(input logic [8:0] a, input logic [31:0] e, input logic [31:0] m);
        rq.push_back({m, e});
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic drain();
        int n;
        n = 0;
        while ((gq.size() + bq.size() + rq.size()) != 0) begin
            @(posedge mclk);
            n++;
            if (n > 3000) begin
                mismatches++;
                test_done();
            end
        end
    endtask

    // Drop all requests and wait for the slave to fall free
    task automatic quiet();
        int n;
        chk_en = 1'b0;
        bt_en = 1'b0;
        req <= 6'h00;
        n = 0;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (grant_valid !== 1'b0 && n < 400);
        if (n >= 400) begin
            mismatches++;
            test_done();
        end
    endtask

    // One nibble per expected grant, first grant in the lowest nibble
    task automatic grants(input logic [31:0] seq, input int n);
        for (int k = 0; k < n; k++) begin
            gq.push_back({29'h0, seq[4*k +: 3]});
        end
        chk_en = 1'b1;
        req <= 6'h3f;
        drain();
        quiet();
    endtask

    // Beats master 0 completes before the slave is handed over
    task automatic beats(input logic [31:0] e);
        bq.push_back(e);
        bt_en = 1'b1;
        req <= 6'h03;
        drain();
        quiet();
    endtask

    // Watcher: read data one cycle after the strobe, grant changes, owner beats
    always @(posedge mclk) begin
        logic [63:0] e;
        if (rd_pend && rq.size() > 0) begin
            e = rq.pop_front();
            chk(reg_rdata & e[63:32], e[31:0] & e[63:32]);
        end
        rd_pend = reg_rd;
        if (grant_valid === 1'b1 && (!pv || grant_idx !== pi)) begin
            if (bt_en && pv && pi == 3'h0 && bq.size() > 0) chk(bcnt, bq.pop_front());
            if (chk_en && gq.size() > 0) chk({29'h0, grant_idx}, gq.pop_front());
            bcnt = 32'h0;
        end
        if (grant_valid && bus_htrans != AMSA_HT_IDLE && bus_hready) bcnt++;
        pv = grant_valid;
        pi = grant_idx;
    end

    initial begin
        void'($urandom(80));
        rst <= 1'b1;
        req <= 6'h00;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_addr <= 9'h000;
        reg_wdata <= 32'h0;
        bus_lock <= 1'b0;
        slow <= 1'b1;
        ce <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            hb[i] <= i[0] ? AMSA_HB_INCR4 : AMSA_HB_SINGLE;
            ln[i] <= i[0] ? 9'h004 : 9'h001;
        end
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        // Reset contents, unmapped hole, slot field read back
        rd(AMSA_MCFG_BASE, 32'h0, 32'h7);
        rd(AMSA_PRIO_A_OFF, AMSA_PRIO_RST, 32'hffffffff);
        rd(AMSA_SCFG_OFF, 32'h1ff, 32'h1ff);
        rd(AMSA_WPSR_OFF, 32'h0, 32'hffffffff);
        rd(9'h100, 32'h0, 32'hffffffff);
        d = $urandom;
        wr(AMSA_SCFG_OFF, d);
        rd(AMSA_SCFG_OFF, d, 32'h1ff);
        wr(AMSA_SCFG_OFF, 32'h0);
        // Clock enable low: a write in that cycle must not land
        ce <= 1'b0;
        wr(AMSA_SCFG_OFF, 32'h005);
        ce <= 1'b1;
        rd(AMSA_SCFG_OFF, 32'h0, 32'h1ff);
        // Pool orders: plain rotation, top pool rotation, middle pool by index
        grants(32'h10543210, 8);
        wr(AMSA_PRIO_A_OFF, 32'h00303113);
        grants(32'h00530530, 6);
        wr(AMSA_PRIO_A_OFF, 32'h00020120);
        grants(32'h00141414, 6);
        wr(AMSA_PRIO_A_OFF, 32'h0);
        // Every burst limit code against a long INCR of master 0
        hb[0] <= AMSA_HB_INCR;
        ln[0] <= 9'h0c8;
        hb[1] <= AMSA_HB_SINGLE;
        ln[1] <= 9'h001;
        for (int c = 0; c < 8; c++) begin
            wr(AMSA_MCFG_BASE, c);
            rd(AMSA_MCFG_BASE, c, 32'h7);
            rd(9'h004, 32'h0, 32'h7);
            beats(c == 0 ? 200 : c == 1 ? 1 : 1 << c);
        end
        // Slot budget: break, lock holds off, zero disables
        wr(AMSA_MCFG_BASE, 32'h0);
        ln[0] <= 9'h028;
        slow <= 1'b0;
        wr(AMSA_SCFG_OFF, 32'h00a);
        beats(11);
        bus_lock <= 1'b1;
        beats(40);
        bus_lock <= 1'b0;
        wr(AMSA_SCFG_OFF, 32'h0);
        beats(40);
        // Write protect: blocked writes, source, keyed clear only
        wr(AMSA_WPMR_OFF, {AMSA_PROT_KEY, 8'h01});
        rd(AMSA_WPMR_OFF, 32'h1, 32'h1);
        d = $urandom;
        wr(AMSA_PRIO_A_OFF, d);
        rd(AMSA_PRIO_A_OFF, 32'h0, 32'hffffffff);
        rd(AMSA_WPSR_OFF, {17'h0, 7'h20, 8'h01}, 32'h7f01);
        wr(9'h1fc, d);
        rd(AMSA_WPSR_OFF, {17'h0, 7'h7f, 8'h01}, 32'h7f01);
        wr(AMSA_WPMR_OFF, {~AMSA_PROT_KEY, 8'h00});
        rd(AMSA_WPSR_OFF, 32'h1, 32'h1);
        rd(AMSA_WPMR_OFF, 32'h1, 32'h1);
        wr(AMSA_WPMR_OFF, {AMSA_PROT_KEY, 8'h00});
        rd(AMSA_WPSR_OFF, 32'h0, 32'h1);
        wr(AMSA_PRIO_A_OFF, d);
        rd(AMSA_PRIO_A_OFF, d, 32'h00333333);
        drain();
        test_done();
    end
endmodule // testbench
`default_nettype wire

//--- verilog/amsa_pkg.sv
// Package for the slave port arbiter: offsets, fields, reset values and AHB codes.
`default_nettype none
package amsa_pkg;
    // Register byte offsets
    localparam logic [8:0] AMSA_MCFG_BASE = 9'h000;
    localparam logic [8:0] AMSA_SCFG_OFF = 9'h040;
    localparam logic [8:0] AMSA_PRIO_A_OFF = 9'h080;
    localparam logic [8:0] AMSA_WPMR_OFF = 9'h1e4;
    localparam logic [8:0] AMSA_WPSR_OFF = 9'h1e8;
    localparam logic [8:0] AMSA_PROT_LO = 9'h000;
    localparam logic [8:0] AMSA_PROT_HI = 9'h1fc;
    // Field positions and widths
    localparam int AMSA_BLIM_W = 3;
    localparam int AMSA_SLOT_W = 9;
    localparam int AMSA_POOL_STRIDE = 4;
    localparam int AMSA_KEY_LSB = 8;
    localparam int AMSA_KEY_W = 24;
    localparam int AMSA_SRC_LSB = 8;
    localparam int AMSA_SRC_W = 7;
    // Reset values
    localparam logic [2:0] AMSA_BLIM_RST = 3'h0;
    localparam logic [8:0] AMSA_SLOT_RST = 9'h1ff;
    localparam logic [31:0] AMSA_PRIO_RST = 32'h0000_0000;
    // Access key of the protect mode register; value is arbitrary
    localparam logic [23:0] AMSA_PROT_KEY = 24'h5a3c96;
    // AHB transfer type codes
    localparam logic [1:0] AMSA_HT_IDLE = 2'h0;
    localparam logic [1:0] AMSA_HT_NONSEQ = 2'h2;
    // AHB burst codes
    localparam logic [2:0] AMSA_HB_SINGLE = 3'h0;
    localparam logic [2:0] AMSA_HB_INCR = 3'h1;
    localparam logic [2:0] AMSA_HB_WRAP4 = 3'h2;
    localparam logic [2:0] AMSA_HB_INCR4 = 3'h3;
    localparam logic [2:0] AMSA_HB_WRAP8 = 3'h4;
    localparam logic [2:0] AMSA_HB_INCR8 = 3'h5;
    localparam logic [2:0] AMSA_HB_WRAP16 = 3'h6;
    // Undefined burst limit encodings
    typedef enum logic [2:0] {
        AMSA_UL_UNLIM, AMSA_UL_1, AMSA_UL_4, AMSA_UL_8,
        AMSA_UL_16, AMSA_UL_32, AMSA_UL_64, AMSA_UL_128
    } amsa_blim_e;
endpackage
`default_nettype wire

//--- verilog/amsa_slave_arbiter.sv
// Per-slave arbiter with burst prediction, slot limit, priority pools and write protect.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - One-beat limit ends burst every INCR beat
// - Limits 4..128 end burst at each boundary
// - Burst limit resets to unlimited, zero
// - Each master owns its burst limit
// - Slot counter loads at grant, decrements
// - Expired slot allows rearbitration after beat
// - Slot budget zero disables the limit
// - Locked transfers are never broken by slot
// - Round-robin in top/bottom pools, fixed otherwise
// - Pool level considered once the current owner is dropped
// - All pool levels reset to zero
// - Top pool waits at most one round
// - Any pool level assignment is accepted
// - No repeat grant while others request
// - Numerically highest pool level wins first
// - Intermediate pool ties go highest index
// - Round-robin in increasing master index
// - Protect bit blocks configuration writes
// - Blocked write sets flag and source
// - Only keyed mode write clears flag
// - Unlimited INCR gives no predicted end
// - Rearbitrate only at idle, single, end, slot
module amsa_slave_arbiter
    import amsa_pkg::*;
#(
    parameter int NM = 6,
    parameter int LW = 2
) (
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    // Master requests
    input wire logic [NM-1:0] req,
    // Slave-side AHB signals of the current owner
    input wire logic [1:0] bus_htrans,
    input wire logic [2:0] bus_hburst,
    input wire logic bus_hready,
    input wire logic bus_lock,
    // Register port
    input wire logic [8:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Grant
    output logic grant_valid,
    output logic [$clog2(NM)-1:0] grant_idx
);
    localparam int IW = $clog2(NM);
    localparam logic [LW-1:0] TOP = {LW{1'b1}};

    // Refuse sizes the register layout cannot hold
    if (NM < 2 || NM * AMSA_POOL_STRIDE > 32 || LW < 1 || LW > AMSA_POOL_STRIDE) begin : g_bad_size
        $error("amsa_slave_arbiter: unsupported NM or LW");
    end

    logic [AMSA_BLIM_W-1:0] undef_burst_limit_q [NM];
    logic [AMSA_SLOT_W-1:0] slot_budget_q;
    logic [31:0] prio_q;
    logic protect_on_q;
    logic protect_violation_q;
    logic [AMSA_SRC_W-1:0] violation_source_q;
    logic [31:0] rdata_q;
    logic grant_valid_q;
    logic [IW-1:0] grant_idx_q;
    logic [AMSA_SLOT_W-1:0] slot_cnt_q;
    logic [7:0] beat_cnt_q;
    logic [IW-1:0] rr_lo_q;
    logic [IW-1:0] rr_hi_q;

    // Write decode and protection
    logic keyed_wpmr;
    logic in_prot;
    logic blocked;
    logic wr_ok;
    assign keyed_wpmr = reg_wr && reg_addr == AMSA_WPMR_OFF
                        && reg_wdata[AMSA_KEY_LSB +: AMSA_KEY_W] == AMSA_PROT_KEY;
    assign in_prot = reg_addr >= AMSA_PROT_LO && reg_addr <= AMSA_PROT_HI;
    assign blocked = reg_wr && protect_on_q && in_prot && !keyed_wpmr;
    assign wr_ok = reg_wr && !blocked;

    // Master configuration: one burst limit per master
    always_ff @(posedge mclk) begin
        for (int i = 0; i < NM; i++) begin
            if (rst) begin
                undef_burst_limit_q[i] <= AMSA_BLIM_RST;
            end else if (ce && wr_ok && reg_addr == AMSA_MCFG_BASE + 9'(4 * i)) begin
                undef_burst_limit_q[i] <= reg_wdata[AMSA_BLIM_W-1:0];
            end
        end
    end

    // Slave configuration and pool levels
    always_ff @(posedge mclk) begin
        if (rst) begin
            slot_budget_q <= AMSA_SLOT_RST;
            prio_q <= AMSA_PRIO_RST;
        end else if (ce && wr_ok) begin
            if (reg_addr == AMSA_SCFG_OFF) begin
                slot_budget_q <= reg_wdata[AMSA_SLOT_W-1:0];
            end
            if (reg_addr == AMSA_PRIO_A_OFF) begin
                prio_q <= reg_wdata;
            end
        end
    end

    // Protect mode: changes only with the key, even when unprotected
    always_ff @(posedge mclk) begin
        if (rst) begin
            protect_on_q <= 1'b0;
        end else if (ce && keyed_wpmr) begin
            protect_on_q <= reg_wdata[0];
        end
    end

    // Violation flag: a new violation wins over a clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            protect_violation_q <= 1'b0;
            violation_source_q <= '0;
        end else if (ce && blocked) begin
            protect_violation_q <= 1'b1;
            violation_source_q <= reg_addr[8:2];
        end else if (ce && keyed_wpmr) begin
            protect_violation_q <= 1'b0;
        end
    end

    // Read data, one cycle after the strobe; holes read zero
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_q <= '0;
        end else if (ce) begin
            rdata_q <= '0;
            if (reg_rd) begin
                for (int i = 0; i < NM; i++) begin
                    if (reg_addr == AMSA_MCFG_BASE + 9'(4 * i)) begin
                        rdata_q <= 32'(undef_burst_limit_q[i]);
                    end
                end
                if (reg_addr == AMSA_SCFG_OFF) begin
                    rdata_q <= 32'(slot_budget_q);
                end
                if (reg_addr == AMSA_PRIO_A_OFF) begin
                    rdata_q <= prio_q;
                end
                if (reg_addr == AMSA_WPMR_OFF) begin
                    rdata_q <= 32'(protect_on_q);
                end
                if (reg_addr == AMSA_WPSR_OFF) begin
                    rdata_q <= 32'({violation_source_q, 7'h00, protect_violation_q});
                end
            end
        end
    end
    assign reg_rdata = rdata_q;

    // Limit code to beat count minus one
    function automatic logic [7:0] lim_m1(input logic [2:0] code);
        logic [7:0] r;
        r = 8'h00;
        unique case (amsa_blim_e'(code))
            AMSA_UL_UNLIM: r = 8'h00;
            AMSA_UL_1: r = 8'h00;
            AMSA_UL_4: r = 8'h03;
            AMSA_UL_8: r = 8'h07;
            AMSA_UL_16: r = 8'h0f;
            AMSA_UL_32: r = 8'h1f;
            AMSA_UL_64: r = 8'h3f;
            AMSA_UL_128: r = 8'h7f;
        endcase
        return r;
    endfunction

    // Beat position and end-of-burst detection
    logic active;
    logic beat_done;
    logic [7:0] beat_idx;
    logic [2:0] own_limit;
    logic [7:0] own_m1;
    logic end_of_burst;
    logic slot_exp;
    logic arb_pt;
    assign active = bus_htrans[1];
    assign beat_done = active && bus_hready;
    assign beat_idx = (bus_htrans == AMSA_HT_NONSEQ) ? 8'h00 : beat_cnt_q;
    assign own_limit = undef_burst_limit_q[grant_idx_q];
    assign own_m1 = lim_m1(own_limit);

    always_comb begin
        end_of_burst = 1'b0;
        unique case (bus_hburst)
            AMSA_HB_SINGLE: end_of_burst = beat_done;
            // Unlimited INCR only ends by idle or slot
            AMSA_HB_INCR: end_of_burst = beat_done && own_limit != 3'(AMSA_UL_UNLIM)
                                         && (beat_idx & own_m1) == own_m1;
            AMSA_HB_WRAP4, AMSA_HB_INCR4: end_of_burst = beat_done && beat_idx == 8'h03;
            AMSA_HB_WRAP8, AMSA_HB_INCR8: end_of_burst = beat_done && beat_idx == 8'h07;
            default: end_of_burst = beat_done && beat_idx == 8'h0f;
        endcase
    end

    // Expiry only counts when a budget is programmed; lock holds the owner
    assign slot_exp = slot_budget_q != '0 && slot_cnt_q == '0 && grant_valid_q;
    assign arb_pt = !grant_valid_q || bus_htrans == AMSA_HT_IDLE || end_of_burst
                    || (slot_exp && bus_hready && !bus_lock);

    always_ff @(posedge mclk) begin
        if (rst) begin
            beat_cnt_q <= 8'h00;
        end else if (ce && beat_done) begin
            beat_cnt_q <= beat_idx + 8'h01;
        end
    end

    // Round-robin pick: first candidate after the pointer, upward
    function automatic logic [IW-1:0] rr_pick(input logic [NM-1:0] cand, input logic [IW-1:0] ptr);
        logic [IW-1:0] r;
        logic found;
        int idx;
        r = '0;
        found = 1'b0;
        for (int k = 1; k <= NM; k++) begin
            idx = (int'(ptr) + k) % NM;
            if (!found && cand[idx]) begin
                r = IW'(idx);
                found = 1'b1;
            end
        end
        return r;
    endfunction

    // Winner selection
    logic [NM-1:0] mreq;
    logic [NM-1:0] cand;
    logic [LW-1:0] best;
    logic [IW-1:0] win_idx;
    logic win_valid;
    logic multi_req;
    always_comb begin
        mreq = req;
        multi_req = ($countones(req) > 1);
        if (multi_req && grant_valid_q) begin
            mreq[grant_idx_q] = 1'b0;
        end
        best = '0;
        for (int i = 0; i < NM; i++) begin
            if (mreq[i] && prio_q[AMSA_POOL_STRIDE * i +: LW] > best) begin
                best = prio_q[AMSA_POOL_STRIDE * i +: LW];
            end
        end
        cand = '0;
        for (int i = 0; i < NM; i++) begin
            cand[i] = mreq[i] && prio_q[AMSA_POOL_STRIDE * i +: LW] == best;
        end
        win_valid = |mreq;
        win_idx = '0;
        if (best == '0) begin
            win_idx = rr_pick(cand, rr_lo_q);
        end else if (best == TOP) begin
            win_idx = rr_pick(cand, rr_hi_q);
        end else begin
            for (int i = 0; i < NM; i++) begin
                if (cand[i]) begin
                    win_idx = IW'(i);
                end
            end
        end
    end

    // Winner level against every requester in mreq, worked out apart from the pick
    logic [LW-1:0] win_lvl;
    logic win_lvl_top;
    always_comb begin
        win_lvl = prio_q[AMSA_POOL_STRIDE * int'(win_idx) +: LW];
        win_lvl_top = 1'b1;
        for (int i = 0; i < NM; i++) begin
            if (mreq[i] && prio_q[AMSA_POOL_STRIDE * i +: LW] > win_lvl) begin
                win_lvl_top = 1'b0;
            end
        end
    end

    // Grant register: moves only at an arbitration point
    always_ff @(posedge mclk) begin
        if (rst) begin
            grant_valid_q <= 1'b0;
            grant_idx_q <= '0;
        end else if (ce && arb_pt) begin
            grant_valid_q <= win_valid;
            if (win_valid) begin
                grant_idx_q <= win_idx;
            end
        end
    end
    assign grant_valid = grant_valid_q;
    assign grant_idx = grant_idx_q;

    // Round-robin pointers, one per round-robin pool
    always_ff @(posedge mclk) begin
        if (rst) begin
            rr_lo_q <= IW'(NM - 1);
            rr_hi_q <= IW'(NM - 1);
        end else if (ce && arb_pt && win_valid) begin
            if (best == '0) begin
                rr_lo_q <= win_idx;
            end else if (best == TOP) begin
                rr_hi_q <= win_idx;
            end
        end
    end

    // Slot counter; idles at zero to save toggling
    always_ff @(posedge mclk) begin
        if (rst) begin
            slot_cnt_q <= '0;
        end else if (ce) begin
            if (arb_pt && win_valid) begin
                slot_cnt_q <= slot_budget_q;
            end else if (slot_cnt_q != '0) begin
                slot_cnt_q <= slot_cnt_q - AMSA_SLOT_W'(1);
            end
        end
    end

    // Checks
    a_viol_sets: assert property (@(posedge mclk) disable iff (rst)
        ce && blocked |=> protect_violation_q && violation_source_q == $past(reg_addr[8:2]))
        else $error("violation flag or source not recorded");
    a_flag_holds: assert property (@(posedge mclk) disable iff (rst)
        protect_violation_q && !(ce && keyed_wpmr) |=> protect_violation_q)
        else $error("violation flag cleared without keyed write");
    a_blocked_cfg: assert property (@(posedge mclk) disable iff (rst)
        ce && blocked && reg_addr == AMSA_SCFG_OFF |=> $stable(slot_budget_q))
        else $error("protected write changed configuration");
    a_no_repeat: assert property (@(posedge mclk) disable iff (rst)
        ce && arb_pt && multi_req && grant_valid_q |=> grant_idx_q != $past(grant_idx_q))
        else $error("same master granted twice while others requested");
    a_level_first: assert property (@(posedge mclk) disable iff (rst)
        ce && arb_pt && win_valid |-> mreq[win_idx] && win_lvl_top)
        else $error("lower pool level granted over higher");
    a_slot_load: assert property (@(posedge mclk) disable iff (rst)
        ce && arb_pt && win_valid |=> slot_cnt_q == $past(slot_budget_q))
        else $error("slot counter not loaded at arbitration");
    a_slot_dec: assert property (@(posedge mclk) disable iff (rst)
        ce && !arb_pt && slot_cnt_q != '0 |=> slot_cnt_q == $past(slot_cnt_q) - 1'b1)
        else $error("slot counter did not decrement");
    a_grant_hold: assert property (@(posedge mclk) disable iff (rst)
        !arb_pt ##1 !arb_pt |-> $stable(grant_idx_q) && $stable(grant_valid_q))
        else $error("grant moved outside an arbitration point");
    a_unlim_none: assert property (@(posedge mclk) disable iff (rst)
        grant_valid_q && bus_hburst == AMSA_HB_INCR && own_limit == 3'h0 && active && !slot_exp
        |-> !arb_pt)
        else $error("predicted end raised with unlimited setting");
    a_one_beat: assert property (@(posedge mclk) disable iff (rst)
        bus_hburst == AMSA_HB_INCR && own_limit == 3'h1 && beat_done |-> arb_pt)
        else $error("one-beat limit did not end the beat");
    a_rdata_idle: assert property (@(posedge mclk) disable iff (rst)
        ce && !reg_rd |=> reg_rdata == '0)
        else $error("read data not zero outside the answer cycle");
    c_grant_move: cover property (@(posedge mclk) disable iff (rst)
        ce && arb_pt && multi_req ##1 grant_idx_q != $past(grant_idx_q));
    c_violation: cover property (@(posedge mclk) disable iff (rst) ce && blocked);
    c_slot_break: cover property (@(posedge mclk) disable iff (rst) slot_exp && bus_hready && active);
    c_pred_end: cover property (@(posedge mclk) disable iff (rst)
        bus_hburst == AMSA_HB_INCR && end_of_burst && beat_idx != 8'h00);
endmodule // amsa_slave_arbiter
`default_nettype wire
